// [rscfg_board.sv]
`timescale 1ns/10ps
`default_nettype none
module rscfg_board (
   input wire logic clock_i,
   input wire logic pin_low_i,
   input wire logic trst_low_i,
   input wire logic drive_i,
   input wire logic [13:0] strap_i,
   input wire logic take_i,
   output logic pin_resetn_o,
   output logic test_resetn_o,
   output logic [13:0] addr_o
);
   logic [13:0] bus = 14'h0;
   always @(posedge clock_i) bus <= bus + 14'h1357;
   assign pin_resetn_o = !pin_low_i;
   assign test_resetn_o = !trst_low_i;
   // Pull-downs when undriven; memory traffic moves every cycle once handed over
   assign addr_o = take_i ? bus : drive_i ? strap_i : 14'h0;
endmodule
`default_nettype wire

// [rscfg_pkg.sv]
`default_nettype none
package rscfg_pkg;
   // Strap field positions on the async address bus, then address bus, module reset and mux register widths
   localparam int BOOT_SEL_LSB = 11;
   localparam int BUS_CFG_LSB = 8;
   localparam int BUS_WIDTH_BIT = 2;
   localparam int ADDR_W = 14;
   localparam int MOD_COUNT = 44;
   localparam int MUX_W = 32;
   // Reset values
   localparam logic [2:0] BOOT_SEL_RST = 3'h0;
   localparam logic [2:0] BUS_CFG_RST = 3'h0;
   localparam logic OSC_CFG_RST = 1'h0;
   localparam logic [MUX_W-1:0] MUX_RST = 32'h0000_0000;
   // Cycles the internal reset pulses stay asserted after the cause goes away
   localparam int RST_STRETCH_CYC = 8;
   localparam logic [3:0] RST_STRETCH = 4'h8;
   typedef enum logic [2:0] {
      BOOT_NAND = 3'h0, BOOT_ASYNC = 3'h1, BOOT_MMCSD = 3'h2, BOOT_UART = 3'h3,
      BOOT_USB = 3'h4, BOOT_SPI = 3'h5, BOOT_ETH = 3'h6, BOOT_HOST = 3'h7
   } rscfg_boot_t;
   typedef enum logic [2:0] {
      ST_COLD = 3'b001, ST_STRAP = 3'b010, ST_RUN = 3'b100
   } rscfg_state_t;
endpackage
`default_nettype wire

// [rscfg_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module rscfg_properties (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic boot_done_i,
   input wire logic por_o,
   input wire logic warm_reset_o,
   input wire logic sys_reset_o,
   input wire logic [43:0] module_reset_o,
   input wire logic [2:0] boot_select_o,
   input wire logic [2:0] async_bus_config_o,
   input wire logic bus_16bit_o,
   input wire logic straps_valid_o,
   input wire logic pll_bypass_o,
   input wire logic pll_enable_o,
   input wire logic default_config_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   property p_por; por_o |-> warm_reset_o; endproperty
   a_por: assert property (p_por) else $error("por alone");
   // Two cycles allow one flop of skew between the outputs
   property p_mod; warm_reset_o [*2] |-> &module_reset_o; endproperty
   a_mod: assert property (p_mod) else $error("module free");
   property p_sys; sys_reset_o |-> !warm_reset_o; endproperty
   a_sys: assert property (p_sys) else $error("soft in hard");
   property p_pll; warm_reset_o |=> pll_bypass_o && !pll_enable_o; endproperty
   a_pll: assert property (p_pll) else $error("no bypass");
   property p_dflt; $rose(straps_valid_o) |-> default_config_o; endproperty
   a_dflt: assert property (p_dflt) else $error("no default");
   property p_boot; $fell(default_config_o) |-> $past(boot_done_i); endproperty
   a_boot: assert property (p_boot) else $error("early exit");
   property p_bus; straps_valid_o |-> bus_16bit_o == async_bus_config_o[2]; endproperty
   a_bus: assert property (p_bus) else $error("bus width");
   property p_hold; straps_valid_o [*2] |-> $stable({boot_select_o, async_bus_config_o}); endproperty
   a_hold: assert property (p_hold) else $error("straps moved");
endmodule
bind rscfg_top rscfg_properties u_rscfg_properties (.*);
`default_nettype wire

// [rscfg_stretch.sv]
`timescale 1ns/10ps
`default_nettype none
// Holds a reset output for a fixed number of cycles after its cause clears
module rscfg_stretch (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic cause_i,
   output logic active_o
);
   import rscfg_pkg::*;
   logic [3:0] count;
   wire count_busy = (count != 4'h0);
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count <= RST_STRETCH;
         active_o <= 1'b1;
      end else begin
         if (cause_i) begin
            count <= RST_STRETCH;
         end else if (count_busy) begin
            count <= count - 4'h1;
         end
         active_o <= cause_i | count_busy;
      end
   end
endmodule
`default_nettype wire

// [rscfg_top.sv]
`timescale 1ns/10ps
`default_nettype none
module rscfg_top (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic pin_resetn_i,
   input wire logic test_resetn_i,
   input wire logic emu_max_reset_i,
   input wire logic watchdog_reset_i,
   input wire logic emu_sys_reset_i,
   input wire logic [rscfg_pkg::ADDR_W-1:0] async_address_bus_i,
   input wire logic oscillator_strap_pin_i,
   input wire logic [rscfg_pkg::MOD_COUNT-1:0] module_reset_req_i,
   input wire logic [2:0] mux_sel_i,
   input wire logic [rscfg_pkg::MUX_W-1:0] mux_wdata_i,
   input wire logic mux_we_i,
   input wire logic boot_done_i,
   output logic por_o,
   output logic warm_reset_o,
   output logic sys_reset_o,
   output logic [rscfg_pkg::MOD_COUNT-1:0] module_reset_o,
   output logic [2:0] boot_select_o,
   output logic [2:0] async_bus_config_o,
   output logic bus_16bit_o,
   output logic oscillator_config_o,
   output logic straps_valid_o,
   output logic pins_to_async_o,
   output logic pll_bypass_o,
   output logic pll_enable_o,
   output logic default_config_o,
   output logic [rscfg_pkg::MUX_W-1:0] video_in_mux_register_o,
   output logic [rscfg_pkg::MUX_W-1:0] video_out_mux_register_o,
   output logic [rscfg_pkg::MUX_W-1:0] address_mux_register_o,
   output logic [rscfg_pkg::MUX_W-1:0] general_io_mux_register_o,
   output logic [rscfg_pkg::MUX_W-1:0] serial_card_mux_register_o
);
   import rscfg_pkg::*;

   // ==========================================
   // Input synchronisers
   // ==========================================
   logic [5:0] sync1;
   logic [5:0] sync2;
   logic [ADDR_W:0] strap_s1;
   logic [ADDR_W:0] strap_s2;
   wire [5:0] raw_in = {pin_resetn_i, test_resetn_i, emu_max_reset_i, watchdog_reset_i,
                        emu_sys_reset_i, 1'b0};
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync1 <= 6'h30;
         sync2 <= 6'h30;
         strap_s1 <= '0;
         strap_s2 <= '0;
      end else begin
         sync1 <= raw_in;
         sync2 <= sync1;
         strap_s1 <= {oscillator_strap_pin_i, async_address_bus_i};
         strap_s2 <= strap_s1;
      end
   end
   wire pin_low = !sync2[5];
   wire test_low = !sync2[4];
   wire cold_cause = pin_low & test_low;
   // Max reset folds into the warm path so both behave identically
   wire warm_cause = pin_low | sync2[3] | sync2[2];
   wire sys_cause = sync2[1];

   // ==========================================
   // Reset pulse generation
   // ==========================================
   wire por_act;
   wire warm_act;
   wire sys_act;
   rscfg_stretch u_por (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .cause_i(cold_cause),
      .active_o(por_act)
   );
   rscfg_stretch u_warm (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .cause_i(warm_cause | cold_cause),
      .active_o(warm_act)
   );
   rscfg_stretch u_sys (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .cause_i(sys_cause),
      .active_o(sys_act)
   );
   wire hard_reset = warm_act | por_act;

   // ==========================================
   // Strap capture sequence
   // ==========================================
   rscfg_state_t state;
   rscfg_state_t next_state;
   always_comb begin
      next_state = state;
      case (state)
         ST_COLD: if (!hard_reset) begin
            next_state = ST_STRAP;
         end
         ST_STRAP: next_state = ST_RUN;
         ST_RUN: if (hard_reset) begin
            next_state = ST_COLD;
         end
         default: next_state = ST_COLD;
      endcase
   end
   wire capture = (state == ST_STRAP);
   wire [2:0] boot_strap = strap_s2[BOOT_SEL_LSB +: 3];
   wire [2:0] bus_strap = strap_s2[BUS_CFG_LSB +: 3];
   wire osc_strap = strap_s2[ADDR_W];
   // Bus config only seeds the address mux; software owns it afterwards
   wire [MUX_W-1:0] addr_mux_seed = {29'h0, bus_strap};

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= ST_COLD;
      end else begin
         state <= next_state;
      end
   end

   // Soft system reset deliberately leaves straps, clocks and muxing alone
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         boot_select_o <= BOOT_SEL_RST;
         async_bus_config_o <= BUS_CFG_RST;
         bus_16bit_o <= 1'b0;
         oscillator_config_o <= OSC_CFG_RST;
         straps_valid_o <= 1'b0;
         pins_to_async_o <= 1'b0;
      end else if (hard_reset) begin
         straps_valid_o <= 1'b0;
         pins_to_async_o <= 1'b0;
      end else if (capture) begin
         boot_select_o <= boot_strap;
         async_bus_config_o <= bus_strap;
         bus_16bit_o <= bus_strap[BUS_WIDTH_BIT];
         oscillator_config_o <= osc_strap;
         straps_valid_o <= 1'b1;
         pins_to_async_o <= 1'b1;
      end
   end

   // ==========================================
   // Clock defaults and configuration state
   // ==========================================
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pll_bypass_o <= 1'b1;
         pll_enable_o <= 1'b0;
         default_config_o <= 1'b1;
      end else if (hard_reset) begin
         pll_bypass_o <= 1'b1;
         pll_enable_o <= 1'b0;
         default_config_o <= 1'b1;
      end else if (boot_done_i) begin
         default_config_o <= 1'b0;
      end
   end

   // ==========================================
   // Pin mux registers and module resets
   // ==========================================
   // No legality check on mux values: board and software must agree
   wire wr_ok = mux_we_i & !hard_reset & straps_valid_o;
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         video_in_mux_register_o <= MUX_RST;
         video_out_mux_register_o <= MUX_RST;
         address_mux_register_o <= MUX_RST;
         general_io_mux_register_o <= MUX_RST;
         serial_card_mux_register_o <= MUX_RST;
      end else if (hard_reset) begin
         video_in_mux_register_o <= MUX_RST;
         video_out_mux_register_o <= MUX_RST;
         address_mux_register_o <= MUX_RST;
         general_io_mux_register_o <= MUX_RST;
         serial_card_mux_register_o <= MUX_RST;
      end else if (capture) begin
         address_mux_register_o <= addr_mux_seed;
      end else if (wr_ok) begin
         case (mux_sel_i)
            3'h0: video_in_mux_register_o <= mux_wdata_i;
            3'h1: video_out_mux_register_o <= mux_wdata_i;
            3'h2: address_mux_register_o <= mux_wdata_i;
            3'h3: general_io_mux_register_o <= mux_wdata_i;
            3'h4: serial_card_mux_register_o <= mux_wdata_i;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         por_o <= 1'b1;
         warm_reset_o <= 1'b1;
         sys_reset_o <= 1'b0;
         module_reset_o <= '1;
      end else begin
         por_o <= por_act;
         warm_reset_o <= hard_reset;
         sys_reset_o <= sys_act & !hard_reset;
         module_reset_o <= {MOD_COUNT{hard_reset | sys_act}} | module_reset_req_i;
      end
   end
endmodule
`default_nettype wire

// [rscfg_top_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module rscfg_top_tb;
   logic clock_i = 0, resetn_i = 0, emu_max_reset_i = 0, watchdog_reset_i = 0, emu_sys_reset_i = 0;
   logic mux_we_i = 0, boot_done_i = 0, pin_low = 0, trst_low = 0, drive = 0, pin_resetn_i;
   logic oscillator_strap_pin_i = 0, test_resetn_i, por_o, warm_reset_o, sys_reset_o;
   logic bus_16bit_o, oscillator_config_o, straps_valid_o, pins_to_async_o, pll_bypass_o;
   logic pll_enable_o, default_config_o;
   logic [13:0] strap = 0, async_address_bus_i;
   logic [43:0] module_reset_req_i = 0, module_reset_o;
   logic [2:0] mux_sel_i = 0, boot_select_o, async_bus_config_o, b, c;
   logic [31:0] mux_wdata_i = 0, mx [5];
   int errors = 0, checked = 0, n;
   always #10 clock_i = ~clock_i;
   rscfg_top u_rscfg_top (.*, .video_in_mux_register_o(mx[0]), .video_out_mux_register_o(mx[1]),
      .address_mux_register_o(mx[2]), .general_io_mux_register_o(mx[3]),
      .serial_card_mux_register_o(mx[4]));
   rscfg_board u_rscfg_board (.clock_i, .pin_low_i(pin_low), .trst_low_i(trst_low),
      .drive_i(drive), .strap_i(strap), .take_i(pins_to_async_o), .pin_resetn_o(pin_resetn_i),
      .test_resetn_o(test_resetn_i), .addr_o(async_address_bus_i));
   task cyc(input int k);
      repeat (k) @(posedge clock_i);
      #1;
   endtask
   task chk(input logic [63:0] g, e);
      checked++;
      if (g !== e) begin
         errors++;
         $display("mismatch %0t %h %h", $time, g, e);
      end
   endtask
   task end_of_test;
      if (errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Cause 0 pin, 1 emulator, 2 watchdog, 3 cold
   task hard(input int k);
      {trst_low, pin_low} = {k == 3, k == 0 || k == 3};
      {emu_max_reset_i, watchdog_reset_i} = {k == 1, k == 2};
      cyc(8);
      chk({por_o, warm_reset_o, straps_valid_o, pins_to_async_o, module_reset_o},
          {k == 3, 1'b1, 2'b00, 44'hfff_ffff_ffff});
      {trst_low, pin_low, emu_max_reset_i, watchdog_reset_i} = 4'h0;
      for (n = 0; n < 40 && warm_reset_o !== 1'b0; n++) cyc(1);
      for (n = 0; n < 40 && straps_valid_o !== 1'b1; n++) cyc(1);
      chk({default_config_o, pll_bypass_o, pll_enable_o, pins_to_async_o}, 4'hd);
   endtask
   initial begin
      repeat (4000) @(posedge clock_i);
      errors++;
      end_of_test;
   end
   initial begin
      cyc(6);
      resetn_i = 1;
      // Let the power-up stretch run out so por_o is low before a warm cause
      cyc(12);
      hard(0);
      chk({boot_select_o, async_bus_config_o, oscillator_config_o}, 7'h0);
      for (int i = 0; i < 8; i++) begin
         {b, c} = {i[2:0], ~i[2:0]};
         {drive, strap, oscillator_strap_pin_i} = {1'b1, b, c, 8'h5a, b[0]};
         hard(i % 4);
         chk({boot_select_o, async_bus_config_o, bus_16bit_o}, {b, c, c[2]});
         chk({oscillator_config_o, mx[2]}, {b[0], 29'h0, c});
         cyc(20);
         chk(boot_select_o, b);
      end
      boot_done_i = 1;
      for (int i = 0; i < 6; i++) begin
         {mux_sel_i, mux_wdata_i, mux_we_i} = {i[2:0], 32'h1111_1111 * (i + 1), 1'b1};
         cyc(1);
      end
      {mux_we_i, module_reset_req_i, emu_sys_reset_i} = {1'b0, 44'h200_0000_0021, 1'b1};
      cyc(8);
      chk({sys_reset_o, warm_reset_o, default_config_o}, 3'h4);
      emu_sys_reset_i = 0;
      cyc(20);
      for (int i = 0; i < 5; i++) chk(mx[i], 32'h1111_1111 * (i + 1));
      chk({module_reset_o, boot_select_o}, {module_reset_req_i, 3'h7});
      end_of_test;
   end
endmodule
`default_nettype wire
